// file: mhcs_pkg.sv
// Package for the modulator high carrier select block: offsets, fields, codes
package mhcs_pkg;
  localparam int MHCS_ADR_W = 8;
  localparam int MHCS_DAT_W = 32;
  localparam int MHCS_CTRL_W = 8;
  localparam int MHCS_NSRC = 7;
  localparam int MHCS_NPIN = 5;
  // Register byte offsets
  localparam logic [7:0] MHCS_OFS_CTRL = 8'h00;
  localparam logic [7:0] MHCS_OFS_STAT = 8'h04;
  // Control register fields
  localparam int MHCS_BIT_PIN_DIS = 7;
  localparam int MHCS_BIT_INVERT = 6;
  localparam int MHCS_BIT_SYNC = 5;
  localparam int MHCS_SEL_MSB = 3;
  localparam logic [7:0] MHCS_CTRL_RESET = 8'h00;
  localparam logic [7:0] MHCS_CTRL_WMASK = 8'hef;
  // Status register fields
  localparam int MHCS_STAT_ON_HIGH = 0;
  localparam int MHCS_STAT_PENDING = 1;
  localparam int MHCS_STAT_CARRIER = 2;
  // Source select codes
  localparam logic [3:0] MHCS_SEL_GROUND = 4'h0;
  localparam logic [3:0] MHCS_SEL_CIN1 = 4'h1;
  localparam logic [3:0] MHCS_SEL_CIN2 = 4'h2;
  localparam logic [3:0] MHCS_SEL_REFCLK = 4'h3;
  localparam logic [3:0] MHCS_SEL_CCU1 = 4'h4;
  localparam logic [3:0] MHCS_SEL_CCU2 = 4'h5;
  localparam logic [3:0] MHCS_SEL_CCU3 = 4'h6;
  localparam logic [3:0] MHCS_SEL_CCU4 = 4'h7;
  // Source vector positions
  localparam int MHCS_SRC_CIN1 = 0;
  localparam int MHCS_SRC_CIN2 = 1;
  localparam int MHCS_SRC_REFCLK = 2;
  localparam int MHCS_SRC_CCU1 = 3;
  // Pin disable vector positions
  localparam int MHCS_PIN_REFCLK = 0;
  localparam int MHCS_PIN_CCU1 = 1;
endpackage

// file: mhcs_top.sv
// Modulator high carrier select, conditioning and high-to-low switching
`timescale 1ns/1ps
`default_nettype none
module mhcs_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [mhcs_pkg::MHCS_ADR_W-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [mhcs_pkg::MHCS_DAT_W-1:0] DAT_I,
  output logic [mhcs_pkg::MHCS_DAT_W-1:0] DAT_O,
  output logic ACK_O,
  // Carrier sources
  input wire logic CARRIER_INPUT_PIN_1_I,
  input wire logic CARRIER_INPUT_PIN_2_I,
  input wire logic REFCLK_SIGNAL_I,
  input wire logic [3:0] CAPTURE_COMPARE_OUT_I,
  input wire logic [3:0] CAPTURE_COMPARE_PWM_MODE_I,
  // Modulator switching inputs
  input wire logic MOD_DATA_I,
  input wire logic LOW_CARRIER_I,
  // Outputs
  output logic HI_CARRIER_O,
  output logic MOD_OUT_O,
  output logic [mhcs_pkg::MHCS_NPIN-1:0] SRC_PIN_DISABLE_O
);
  import mhcs_pkg::*;

  // Codes 0100..0111 name the capture/compare units
  function automatic logic is_unit_code(input logic [3:0] sel);
    return sel[3] == 1'b0 && sel[2] == 1'b1;
  endfunction

  // Picks one synchronised source; reserved codes and idle units give zero
  function automatic logic select_carrier(input logic [3:0] sel, input logic [MHCS_NSRC-1:0] src,
                                          input logic [3:0] pwm);
    logic res;
    res = 1'b0;
    if (sel == MHCS_SEL_CIN1) begin
      res = src[MHCS_SRC_CIN1];
    end else if (sel == MHCS_SEL_CIN2) begin
      res = src[MHCS_SRC_CIN2];
    end else if (sel == MHCS_SEL_REFCLK) begin
      res = src[MHCS_SRC_REFCLK];
    end else if (is_unit_code(sel)) begin
      res = src[MHCS_SRC_CCU1 + int'(sel[1:0])] & pwm[sel[1:0]];
    end
    return res;
  endfunction

  // Bus and register state
  logic ack_ff, nxt_ack;
  logic [MHCS_DAT_W-1:0] dat_ff, nxt_dat;
  logic [MHCS_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic bus_req;
  logic [3:0] sel_code;

  assign bus_req = CYC_I & STB_I;
  assign sel_code = ctrl_ff[MHCS_SEL_MSB:0];

  // Source synchronisers
  logic [MHCS_NSRC-1:0] src_meta_ff, src_sync_ff, src_raw;

  assign src_raw = {CAPTURE_COMPARE_OUT_I, REFCLK_SIGNAL_I, CARRIER_INPUT_PIN_2_I, CARRIER_INPUT_PIN_1_I};

  // Carrier conditioning and switching state
  logic hc_ff, nxt_hc;
  logic hc_prev_ff;
  logic on_high_ff, nxt_on_high;
  logic mod_ff, nxt_mod;
  logic [MHCS_NPIN-1:0] pin_dis_ff, nxt_pin_dis;
  logic hc_fall;
  logic carrier_raw;

  assign carrier_raw = select_carrier(sel_code, src_sync_ff, CAPTURE_COMPARE_PWM_MODE_I);
  assign hc_fall = hc_prev_ff & ~hc_ff;

  // Register file next state
  always_comb begin
    nxt_ack = bus_req & ~ack_ff;
    nxt_dat = '0;
    nxt_ctrl = ctrl_ff;
    if (bus_req && !ack_ff) begin
      if (ADR_I == MHCS_OFS_CTRL) begin
        nxt_dat[MHCS_CTRL_W-1:0] = ctrl_ff;
      end else if (ADR_I == MHCS_OFS_STAT) begin
        nxt_dat[MHCS_STAT_ON_HIGH] = on_high_ff;
        nxt_dat[MHCS_STAT_PENDING] = on_high_ff & ~MOD_DATA_I;
        nxt_dat[MHCS_STAT_CARRIER] = hc_ff;
      end
    end
    // Write lands on the edge where the master sees ack, as classic cycles demand
    if (bus_req && ack_ff && WE_I && SEL_I[0] && ADR_I == MHCS_OFS_CTRL) begin
      nxt_ctrl = DAT_I[MHCS_CTRL_W-1:0] & MHCS_CTRL_WMASK;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
      ctrl_ff <= MHCS_CTRL_RESET;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Pins and other clocks reach us asynchronously
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      src_meta_ff <= '0;
      src_sync_ff <= '0;
    end else begin
      src_meta_ff <= src_raw;
      src_sync_ff <= src_meta_ff;
    end
  end

  // Carrier and switch next state
  always_comb begin
    nxt_hc = carrier_raw ^ ctrl_ff[MHCS_BIT_INVERT];
    if (MOD_DATA_I) begin
      nxt_on_high = 1'b1;
    end else if (on_high_ff && ctrl_ff[MHCS_BIT_SYNC] && !hc_fall) begin
      nxt_on_high = 1'b1;
    end else begin
      nxt_on_high = 1'b0;
    end
    // Unsynchronised switching can cut a carrier pulse short
    nxt_mod = nxt_on_high ? hc_ff : LOW_CARRIER_I;
    nxt_pin_dis = '0;
    if (ctrl_ff[MHCS_BIT_PIN_DIS]) begin
      if (sel_code == MHCS_SEL_REFCLK) begin
        nxt_pin_dis[MHCS_PIN_REFCLK] = 1'b1;
      end else if (is_unit_code(sel_code)) begin
        nxt_pin_dis[MHCS_PIN_CCU1 + int'(sel_code[1:0])] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      hc_ff <= 1'b0;
      hc_prev_ff <= 1'b0;
      on_high_ff <= 1'b0;
      mod_ff <= 1'b0;
      pin_dis_ff <= '0;
    end else begin
      hc_ff <= nxt_hc;
      hc_prev_ff <= hc_ff;
      on_high_ff <= nxt_on_high;
      mod_ff <= nxt_mod;
      pin_dis_ff <= nxt_pin_dis;
    end
  end

  assign ACK_O = ack_ff;
  assign DAT_O = dat_ff;
  assign HI_CARRIER_O = hc_ff;
  assign MOD_OUT_O = mod_ff;
  assign SRC_PIN_DISABLE_O = pin_dis_ff;

  // Checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence

  sequence s_ack_pulse;
    ACK_O ##1 !ACK_O;
  endsequence

  property p_ack_pulse;
    s_req |=> s_ack_pulse;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a one cycle answer");

  property p_pin_enabled;
    !ctrl_ff[MHCS_BIT_PIN_DIS] |=> SRC_PIN_DISABLE_O == '0;
  endproperty
  a_pin_enabled: assert property (p_pin_enabled) else $error("pin disabled while bit clear");

  property p_pin_disabled;
    ctrl_ff[MHCS_BIT_PIN_DIS] && sel_code == MHCS_SEL_CCU3 |=> SRC_PIN_DISABLE_O[MHCS_PIN_CCU1 + 2];
  endproperty
  a_pin_disabled: assert property (p_pin_disabled) else $error("selected unit pin not disabled");

  property p_invert;
    ctrl_ff[MHCS_BIT_INVERT] && sel_code == MHCS_SEL_CIN1 |=> HI_CARRIER_O == !$past(src_sync_ff[MHCS_SRC_CIN1]);
  endproperty
  a_invert: assert property (p_invert) else $error("inverted carrier wrong");

  property p_sync_hold;
    on_high_ff && !MOD_DATA_I && ctrl_ff[MHCS_BIT_SYNC] && !hc_fall |=> on_high_ff;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("left high carrier before falling edge");

  sequence s_pending_fall;
    on_high_ff && !MOD_DATA_I && ctrl_ff[MHCS_BIT_SYNC] && hc_fall;
  endsequence

  property p_sync_release;
    s_pending_fall |=> !on_high_ff ##0 (MOD_OUT_O == $past(LOW_CARRIER_I));
  endproperty
  a_sync_release: assert property (p_sync_release) else $error("no switch after falling edge");

  property p_nosync;
    on_high_ff && !MOD_DATA_I && !ctrl_ff[MHCS_BIT_SYNC] |=> !on_high_ff;
  endproperty
  a_nosync: assert property (p_nosync) else $error("unsynchronised switch delayed");

  property p_select_pin2;
    sel_code == MHCS_SEL_CIN2 && !ctrl_ff[MHCS_BIT_INVERT] |=> HI_CARRIER_O == $past(src_sync_ff[MHCS_SRC_CIN2]);
  endproperty
  a_select_pin2: assert property (p_select_pin2) else $error("pin 2 not selected");

  property p_reserved;
    ctrl_ff[3] && !ctrl_ff[MHCS_BIT_INVERT] |=> !HI_CARRIER_O;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code passed a carrier");

  property p_pwm_gate;
    sel_code == MHCS_SEL_CCU2 && !CAPTURE_COMPARE_PWM_MODE_I[1] && !ctrl_ff[MHCS_BIT_INVERT] |=> !HI_CARRIER_O;
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("unit passed outside pwm mode");

  property p_ground;
    sel_code == MHCS_SEL_GROUND && !ctrl_ff[MHCS_BIT_INVERT] |=> !HI_CARRIER_O;
  endproperty
  a_ground: assert property (p_ground) else $error("ground code not low");

  property p_bit4;
    s_req ##0 (ADR_I == MHCS_OFS_CTRL) |=> ACK_O && DAT_O[4] == 1'b0;
  endproperty
  a_bit4: assert property (p_bit4) else $error("bit 4 read as one");

  // While waiting for the falling edge the output keeps tracking the high carrier
  sequence s_waiting;
    on_high_ff && !MOD_DATA_I && ctrl_ff[MHCS_BIT_SYNC] && !hc_fall;
  endsequence

  property p_sync_follow;
    s_waiting |=> MOD_OUT_O == $past(HI_CARRIER_O);
  endproperty
  a_sync_follow: assert property (p_sync_follow) else $error("output left high carrier while waiting");

  property p_low_to_high;
    !on_high_ff && MOD_DATA_I |=> on_high_ff && MOD_OUT_O == $past(HI_CARRIER_O);
  endproperty
  a_low_to_high: assert property (p_low_to_high) else $error("switch to high carrier delayed");

  property p_read_idle;
    !ACK_O |-> DAT_O == '0;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside ack");

  property p_lane_ignored;
    bus_req && ack_ff && WE_I && !SEL_I[0] |=> $stable(ctrl_ff);
  endproperty
  a_lane_ignored: assert property (p_lane_ignored) else $error("write without lane 0 landed");

  property p_status_ro;
    bus_req && ack_ff && WE_I && ADR_I == MHCS_OFS_STAT |=> $stable(ctrl_ff);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write changed control");

  property p_select_pin1;
    sel_code == MHCS_SEL_CIN1 && !ctrl_ff[MHCS_BIT_INVERT] |=> HI_CARRIER_O == $past(src_sync_ff[MHCS_SRC_CIN1]);
  endproperty
  a_select_pin1: assert property (p_select_pin1) else $error("pin 1 not selected");

  property p_select_refclk;
    sel_code == MHCS_SEL_REFCLK && !ctrl_ff[MHCS_BIT_INVERT]
      |=> HI_CARRIER_O == $past(src_sync_ff[MHCS_SRC_REFCLK]);
  endproperty
  a_select_refclk: assert property (p_select_refclk) else $error("reference clock not selected");

  property p_unit_pass;
    sel_code == MHCS_SEL_CCU4 && CAPTURE_COMPARE_PWM_MODE_I[3] && !ctrl_ff[MHCS_BIT_INVERT]
      |=> HI_CARRIER_O == $past(src_sync_ff[MHCS_SRC_CCU1 + 3]);
  endproperty
  a_unit_pass: assert property (p_unit_pass) else $error("unit 4 not passed in pwm mode");

  property p_pin_refclk;
    ctrl_ff[MHCS_BIT_PIN_DIS] && sel_code == MHCS_SEL_REFCLK |=> $onehot(SRC_PIN_DISABLE_O) && SRC_PIN_DISABLE_O[0];
  endproperty
  a_pin_refclk: assert property (p_pin_refclk) else $error("reference clock pin not disabled");

  // Sources without an output pin must never stop another source's pin
  property p_pin_none;
    ctrl_ff[MHCS_BIT_PIN_DIS] && !is_unit_code(sel_code) && sel_code != MHCS_SEL_REFCLK
      |=> SRC_PIN_DISABLE_O == '0;
  endproperty
  a_pin_none: assert property (p_pin_none) else $error("pin disabled for a source without one");
endmodule
`default_nettype wire

// file: mhcs_bench.sv
// Self-checking testbench for the modulator high carrier select block
`timescale 1ns/1ps
`default_nettype none
module mhcs_bench;
  import mhcs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf, lanes = 4'hf;
  logic [31:0] dat_w = 32'h0, dat_r, rd;
  logic ack, cin1 = 1'b0, cin2 = 1'b0, refclk = 1'b0, mod_data = 1'b1, low_car = 1'b0, hc, mod_out;
  logic [3:0] cc = 4'h0, pwm = 4'h0;
  logic [4:0] pin_dis;
  int n_mismatch = 0, n_checks = 0;
  always #5 clk = ~clk;
  mhcs_top u_dut (.CLK_I(clk), .RESET_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .CARRIER_INPUT_PIN_1_I(cin1), .CARRIER_INPUT_PIN_2_I(cin2),
    .REFCLK_SIGNAL_I(refclk), .CAPTURE_COMPARE_OUT_I(cc), .CAPTURE_COMPARE_PWM_MODE_I(pwm),
    .MOD_DATA_I(mod_data), .LOW_CARRIER_I(low_car), .HI_CARRIER_O(hc), .MOD_OUT_O(mod_out),
    .SRC_PIN_DISABLE_O(pin_dis));
  task summarize();
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; the request holds until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    dat_w <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin
      chk("ack", 1, 0);
      summarize();
    end else begin
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask
  function automatic logic exp_hc(logic [3:0] c, logic inv);
    logic s;
    case (c)
      4'h1: s = cin1;
      4'h2: s = cin2;
      4'h3: s = refclk;
      4'h4, 4'h5, 4'h6, 4'h7: s = cc[c - 4'h4] & pwm[c - 4'h4];
      default: s = 1'b0;
    endcase
    return s ^ inv;
  endfunction
  function automatic logic [4:0] exp_pd(logic [3:0] c, logic dis);
    if (!dis || c < 4'h3 || c > 4'h7) return 5'h00;
    return 5'h01 << (c - 4'h3);
  endfunction
  initial begin
    logic [7:0] ctl;
    logic [31:0] r;
    void'($urandom(32'h10a66012));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, MHCS_OFS_CTRL, 0);
    chk("ctrl reset", {24'h0, MHCS_CTRL_RESET}, rd);
    wb(1'b1, MHCS_OFS_CTRL, 32'hffff_ffff);
    wb(1'b0, MHCS_OFS_CTRL, 0);
    chk("ctrl bit4", 32'hef, rd);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b0, 8'h08, 0);
    chk("unmapped", 32'h0, rd);
    // Writes without byte lane 0, or to the status word, leave control alone
    lanes = 4'he;
    wb(1'b1, MHCS_OFS_CTRL, 32'h0);
    lanes = 4'hf;
    wb(1'b1, MHCS_OFS_STAT, 32'h0);
    wb(1'b0, MHCS_OFS_CTRL, 0);
    chk("ctrl kept", 32'hef, rd);
    // Every code, both polarities, random sources and modes
    for (int k = 0; k < 64; k++) begin
      r = $urandom;
      ctl = {r[0], k[4], 1'b0, r[1], k[3:0]};
      wb(1'b1, MHCS_OFS_CTRL, {24'h0, ctl});
      wb(1'b0, MHCS_OFS_CTRL, 0);
      chk("ctrl", {24'h0, ctl & MHCS_CTRL_WMASK}, rd);
      r = $urandom;
      @(posedge clk);
      {cin1, cin2, refclk, cc} <= r[6:0];
      pwm <= k[5] ? 4'hf : r[10:7];
      repeat (5) @(posedge clk);
      chk("carrier", exp_hc(ctl[3:0], ctl[6]), hc);
      chk("mod out", exp_hc(ctl[3:0], ctl[6]), mod_out);
      chk("pin disable", exp_pd(ctl[3:0], ctl[7]), pin_dis);
    end
    // Edge-synchronised switch; low carrier differs from the held high level
    wb(1'b1, MHCS_OFS_CTRL, 32'h21);
    cin1 <= 1'b1;
    low_car <= 1'b0;
    mod_data <= 1'b1;
    repeat (5) @(posedge clk);
    mod_data <= 1'b0;
    repeat (6) @(posedge clk);
    chk("sync hold", 1, mod_out);
    wb(1'b0, MHCS_OFS_STAT, 0);
    chk("status", 32'((1 << MHCS_STAT_ON_HIGH) | (1 << MHCS_STAT_PENDING) | (1 << MHCS_STAT_CARRIER)), rd);
    cin1 <= 1'b0;
    low_car <= 1'b1;
    repeat (6) @(posedge clk);
    chk("sync switch", 1, mod_out);
    // Unsynchronised switch cuts the carrier at once
    wb(1'b1, MHCS_OFS_CTRL, 32'h01);
    cin1 <= 1'b1;
    low_car <= 1'b0;
    mod_data <= 1'b1;
    repeat (5) @(posedge clk);
    chk("high carrier", 1, mod_out);
    mod_data <= 1'b0;
    repeat (2) @(posedge clk);
    chk("no sync", 0, mod_out);
    // Reset in mid-run clears the control register and every output
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    chk("reset outputs", 0, {hc, mod_out, pin_dis, ack});
    rst <= 1'b0;
    wb(1'b0, MHCS_OFS_CTRL, 0);
    chk("ctrl after reset", {24'h0, MHCS_CTRL_RESET}, rd);
    summarize();
  end
endmodule
`default_nettype wire
